// ==== design/ddpl_pkg.sv ====
package ddpl_pkg;
    // apb register map of the controller (one aligned word each)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] DATA_OFF = 8'h04;
    localparam logic [7:0] CMD_OFF = 8'h08;
    localparam logic [7:0] STAT_OFF = 8'h0c;
    localparam logic [7:0] PDX_OFF = 8'h10;
    // ctrl field positions
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_PD_BIT = 4;
    localparam int CTRL_SYNC_BIT = 5;
    localparam int CTRL_BYTE_BIT = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0010;
    // data word layout on a 16-bit bus: code, gain just above, buffer above that
    localparam int DATA_GAIN_BIT = 12;
    localparam int DATA_BUF_BIT = 13;
    // cmd register bits (writes start an action)
    localparam int CMD_WR_BIT = 0;
    localparam int CMD_CH_BIT = 1;
    localparam int CMD_LOAD_BIT = 2;
    localparam int CMD_CLR_BIT = 3;
    localparam int CMD_HI_BIT = 4;
    // pin timing in cycles of pclk (10 MHz)
    localparam int CLK_MHZ = 10;
    localparam int SETUP_NS = 100;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = 2;
    localparam int PDX_US = 5;
    localparam int PDX_CYC = PDX_US * CLK_MHZ;
    localparam logic [7:0] CNT_W8 = 8'h00;
    localparam int NUM_SEL = 4;
    // pin bundle driven toward the converter(s)
    typedef struct packed {
        logic [15:0] data_lines;
        logic channel_select;
        logic upper_byte_select;
        logic [3:0] dev_select_n;
        logic write_strobe_n;
        logic load_outputs_n;
        logic clear_all_n;
        logic power_down_n;
    } ddpl_pins_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_STROBE = 6'b000100,
        ST_HOLD = 6'b001000,
        ST_LOAD = 6'b010000,
        ST_CLEAR = 6'b100000
    } ddpl_state_t;
endpackage : ddpl_pkg

// ==== design/ddpl_host.sv ====
`timescale 1ns/1ps
// Behaviour
// - host bus wide enough, sixteen bits here
// - gain above code, buffer above gain
// - only one device select low at once
// - selects stable while address lines change
// - shared load updates all, shared clear zeroes
module ddpl_host (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter pins
    output ddpl_pkg::ddpl_pins_t pins
);
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] data_reg, data_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic pready_reg, pready_next;
    ddpl_pkg::ddpl_state_t st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;
    logic hi_reg, hi_next;
    logic ch_reg, ch_next;
    logic pdx_busy_reg, pdx_busy_next;
    logic [7:0] pdx_cnt_reg, pdx_cnt_next;
    logic pd_prev_reg, pd_prev_next;
    logic done_reg, done_next;
    ddpl_pkg::ddpl_pins_t pins_reg, pins_next;
    logic wr_acc, rd_acc, busy;

    // one-hot select from ctrl field; the two-bit field always names one of the four selects
    function automatic logic [3:0] sel_dec(input logic [1:0] idx);
        logic [3:0] v;
        v = 4'hf;
        v[idx] = 1'b0;
        return v;
    endfunction : sel_dec

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign busy = (st_reg != ddpl_pkg::ST_IDLE);

    // register file, command sequencer and pin drive
    always_comb begin
        ctrl_next = ctrl_reg;
        data_next = data_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = 1'b0;
        st_next = st_reg;
        cnt_next = cnt_reg;
        hi_next = hi_reg;
        ch_next = ch_reg;
        done_next = done_reg;
        pins_next = pins_reg;
        pd_prev_next = ctrl_reg[ddpl_pkg::CTRL_PD_BIT];
        pdx_busy_next = pdx_busy_reg;
        pdx_cnt_next = pdx_cnt_reg;
        // power-down exit wait tracker
        pins_next.power_down_n = ctrl_reg[ddpl_pkg::CTRL_PD_BIT];
        if (ctrl_reg[ddpl_pkg::CTRL_PD_BIT] && !pd_prev_reg) begin
            pdx_busy_next = 1'b1;
            pdx_cnt_next = 8'(ddpl_pkg::PDX_CYC);
        end else if (pdx_busy_reg) begin
            if (pdx_cnt_reg == ddpl_pkg::CNT_W8 + 8'h01) pdx_busy_next = 1'b0;
            pdx_cnt_next = pdx_cnt_reg - 8'h01;
        end
        // apb access phase: one wait state, answer when pready_reg rises
        if (psel && penable && !pready_reg) begin
            pready_next = 1'b1;
            if (pwrite) begin
                if (paddr == ddpl_pkg::CTRL_OFF) begin
                    ctrl_next = pwdata;
                end else if (paddr == ddpl_pkg::DATA_OFF) begin
                    data_next = pwdata[15:0];
                end else if (paddr == ddpl_pkg::CMD_OFF) begin
                    if (busy) begin
                        pslverr_next = 1'b1; // refused while a sequence runs
                    end else if (pwdata[ddpl_pkg::CMD_CLR_BIT]) begin
                        st_next = ddpl_pkg::ST_CLEAR;
                        cnt_next = 8'(ddpl_pkg::STROBE_CYC);
                        done_next = 1'b0;
                    end else if (pwdata[ddpl_pkg::CMD_WR_BIT]) begin
                        st_next = ddpl_pkg::ST_SETUP;
                        // one cycle to put the lines out, then the setup count before select falls
                        cnt_next = 8'(ddpl_pkg::SETUP_CYC + 1);
                        ch_next = pwdata[ddpl_pkg::CMD_CH_BIT];
                        hi_next = pwdata[ddpl_pkg::CMD_HI_BIT];
                        done_next = 1'b0;
                    end else if (pwdata[ddpl_pkg::CMD_LOAD_BIT]) begin
                        st_next = ddpl_pkg::ST_LOAD;
                        cnt_next = 8'(ddpl_pkg::STROBE_CYC);
                        done_next = 1'b0;
                    end
                end else if (paddr != ddpl_pkg::STAT_OFF && paddr != ddpl_pkg::PDX_OFF) begin
                    pslverr_next = 1'b1;
                end
            end else begin
                if (paddr == ddpl_pkg::CTRL_OFF) begin
                    prdata_next = ctrl_reg;
                end else if (paddr == ddpl_pkg::DATA_OFF) begin
                    prdata_next = {16'h0000, data_reg};
                end else if (paddr == ddpl_pkg::STAT_OFF) begin
                    prdata_next = {29'h0, pdx_busy_reg, done_reg, busy};
                end else if (paddr == ddpl_pkg::PDX_OFF) begin
                    prdata_next = {24'h0, pdx_cnt_reg};
                end else begin
                    prdata_next = 32'h0000_0000;
                    pslverr_next = 1'b1;
                end
            end
        end
        // pin sequencer
        case (st_reg)
            ddpl_pkg::ST_IDLE: begin
                pins_next.dev_select_n = 4'hf;
                pins_next.write_strobe_n = 1'b1;
                pins_next.clear_all_n = 1'b1;
                pins_next.load_outputs_n = ctrl_reg[ddpl_pkg::CTRL_SYNC_BIT] ? 1'b0 : 1'b1;
            end
            ddpl_pkg::ST_SETUP: begin
                // address and data settle before the select falls
                pins_next.channel_select = ch_reg;
                pins_next.upper_byte_select = hi_reg;
                if (!ctrl_reg[ddpl_pkg::CTRL_BYTE_BIT]) begin
                    pins_next.data_lines = data_reg;
                end else if (hi_reg) begin
                    pins_next.data_lines = {8'h00, data_reg[ddpl_pkg::DATA_BUF_BIT],
                        data_reg[ddpl_pkg::DATA_GAIN_BIT], 2'b00, data_reg[11:8]};
                end else begin
                    pins_next.data_lines = {8'h00, data_reg[7:0]};
                end
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == ddpl_pkg::CNT_W8 + 8'h01) begin
                    st_next = ddpl_pkg::ST_STROBE;
                    cnt_next = 8'(ddpl_pkg::STROBE_CYC);
                    pins_next.dev_select_n = sel_dec(ctrl_reg[1:0]);
                    pins_next.write_strobe_n = 1'b0;
                end
            end
            ddpl_pkg::ST_STROBE: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == ddpl_pkg::CNT_W8 + 8'h01) begin
                    pins_next.write_strobe_n = 1'b1;
                    st_next = ddpl_pkg::ST_HOLD;
                end
            end
            ddpl_pkg::ST_HOLD: begin
                pins_next.dev_select_n = 4'hf; // release select after strobe rises
                st_next = ddpl_pkg::ST_IDLE;
                done_next = 1'b1;
            end
            ddpl_pkg::ST_LOAD: begin
                pins_next.load_outputs_n = 1'b0;
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == ddpl_pkg::CNT_W8 + 8'h01) begin
                    st_next = ddpl_pkg::ST_IDLE;
                    done_next = 1'b1;
                end
            end
            ddpl_pkg::ST_CLEAR: begin
                pins_next.clear_all_n = 1'b0;
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == ddpl_pkg::CNT_W8 + 8'h01) begin
                    st_next = ddpl_pkg::ST_IDLE;
                    done_next = 1'b1;
                end
            end
            default: begin
                st_next = ddpl_pkg::ST_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ddpl_pkg::CTRL_RST;
            data_reg <= 16'h0000;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
            st_reg <= ddpl_pkg::ST_IDLE;
            cnt_reg <= 8'h00;
            hi_reg <= 1'b0;
            ch_reg <= 1'b0;
            done_reg <= 1'b0;
            pd_prev_reg <= 1'b1;
            pdx_busy_reg <= 1'b0;
            pdx_cnt_reg <= 8'h00;
            pins_reg <= '{data_lines: 16'h0000, channel_select: 1'b0,
                upper_byte_select: 1'b0, dev_select_n: 4'hf, write_strobe_n: 1'b1,
                load_outputs_n: 1'b1, clear_all_n: 1'b1, power_down_n: 1'b1};
        end else begin
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            hi_reg <= hi_next;
            ch_reg <= ch_next;
            done_reg <= done_next;
            pd_prev_reg <= pd_prev_next;
            pdx_busy_reg <= pdx_busy_next;
            pdx_cnt_reg <= pdx_cnt_next;
            pins_reg <= pins_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pins = pins_reg;
endmodule : ddpl_host

// ==== verification/ddpl_host_asserts.sv ====
`timescale 1ns/1ps
// protocol watch on the controller ports; sees nothing inside the block
module ddpl_host_asserts (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // converter pins
    input wire ddpl_pkg::ddpl_pins_t pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a strobe is two cycles low, the select lifts one cycle after it rises
    sequence s_strobe_low;
        !pins.write_strobe_n [*2];
    endsequence
    sequence s_sel_lift;
        pins.write_strobe_n && pins.dev_select_n != 4'hf ##1 pins.dev_select_n == 4'hf;
    endsequence
    property p_strobe_frame;
        $fell(pins.write_strobe_n) |-> s_strobe_low ##1 s_sel_lift;
    endproperty
    a_strobe_frame: assert property (p_strobe_frame)
        else $error("strobe or select framing wrong");
    property p_one_sel;
        $countones(~pins.dev_select_n) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_strobe_sel;
        !pins.write_strobe_n |-> pins.dev_select_n != 4'hf;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
    // address and data must not move under an active select, or a stray write lands
    property p_stable;
        pins.dev_select_n != 4'hf |-> $stable(pins.data_lines) && $stable(pins.channel_select)
            && $stable(pins.upper_byte_select)
            && ($stable(pins.dev_select_n) || $past(pins.dev_select_n) == 4'hf);
    endproperty
    a_stable: assert property (p_stable) else $error("lines moved under select");
    property p_clear;
        $fell(pins.clear_all_n) |-> !pins.clear_all_n [*2] ##1 pins.clear_all_n;
    endproperty
    a_clear: assert property (p_clear) else $error("clear pulse length wrong");
    property p_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("apb answer late or long");
    property p_unmapped;
        psel && penable && !pready && paddr > 8'h10 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule : ddpl_host_asserts

bind ddpl_host ddpl_host_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins));

// ==== verification/ddpl_dac_model.sv ====
`timescale 1ns/1ps
// clockless load logic of one dual converter on the shared pin bundle
module ddpl_dac_model #(
    parameter int IDX = 0,
    parameter bit BYTE = 1'b0
) (
    // shared pins
    input wire ddpl_pkg::ddpl_pins_t pins,
    // output state per channel as {buffer, gain, code}, and float flag
    output logic [13:0] out_a,
    output logic [13:0] out_b,
    output logic hiz
);
    logic [13:0] in_reg [2] = '{14'h0, 14'h0}; // power-on zero
    logic [1:0] new_reg = 2'h0;
    initial out_a = 14'h0;
    initial out_b = 14'h0;
    // outputs float while powered down, registers untouched
    assign hiz = !pins.power_down_n;
    // only channels rewritten since the last update move
    task automatic update;
        if (new_reg[0]) out_a = in_reg[0];
        if (new_reg[1]) out_b = in_reg[1];
        new_reg = 2'h0;
    endtask : update
    // rising strobe with our select low fills one input register
    always @(posedge pins.write_strobe_n) begin
        if (pins.clear_all_n && !pins.dev_select_n[IDX]) begin
            if (!BYTE) in_reg[pins.channel_select] = pins.data_lines[13:0];
            else if (!pins.upper_byte_select) in_reg[pins.channel_select][7:0] = pins.data_lines[7:0];
            // high byte: code on lines 3:0, gain on line 6, buffer on line 7
            else in_reg[pins.channel_select][13:8] = {pins.data_lines[7:6], pins.data_lines[3:0]};
            new_reg[pins.channel_select] = 1'b1;
            if (!pins.load_outputs_n) update(); // load held low is transparent
        end
    end
    always @(negedge pins.load_outputs_n) if (pins.clear_all_n) update();
    // clear wins over everything and zeroes both stages
    always @(negedge pins.clear_all_n) begin
        in_reg = '{14'h0, 14'h0};
        new_reg = 2'h0;
        out_a = 14'h0;
        out_b = 14'h0;
    end
endmodule : ddpl_dac_model

// ==== verification/ddpl_host_tb_top.sv ====
`timescale 1ns/1ps
// drives the controller over apb and watches two converter models on its pins
module ddpl_host_tb_top;
    typedef struct packed {
        logic ch;
        logic [15:0] data;
        logic [13:0] exp;
    } ddpl_row_t;
    ddpl_row_t rows [4] = '{'{1'b0, 16'h0abc, 14'h0abc}, '{1'b1, 16'h1fff, 14'h1fff},
        '{1'b0, 16'h2001, 14'h2001}, '{1'b1, 16'hc555, 14'h0555}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, hz0, hz1;
    ddpl_pkg::ddpl_pins_t pins;
    logic [13:0] a0, b0, a1, b1;
    logic [13:0] ea = 14'h0;
    logic [13:0] eb = 14'h0;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    always #50 pclk = ~pclk;
    ddpl_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins));
    ddpl_dac_model #(.IDX(0), .BYTE(1'b0)) dev0 (.pins(pins), .out_a(a0), .out_b(b0), .hiz(hz0));
    ddpl_dac_model #(.IDX(1), .BYTE(1'b1)) dev1 (.pins(pins), .out_a(a1), .out_b(b1), .hiz(hz1));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic chk0;
        chk({4'h0, a0, b0}, {4'h0, ea, eb});
    endtask : chk0
    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // bounded wait for the pin sequencer to go idle
    task automatic poll;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, ddpl_pkg::STAT_OFF, 32'h0);
            if (rd[0] === 1'b0) break;
        end
    endtask : poll
    task automatic cmd(input logic [31:0] c);
        apb(1'b1, ddpl_pkg::CMD_OFF, c);
        poll();
        chk(rd & 32'h3, 32'h2);
    endtask : cmd
    // hang guard, well above the few hundred cycles the sequence takes
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk0();
        chk({31'h0, hz0}, 32'h0);
        apb(1'b0, ddpl_pkg::CTRL_OFF, 32'h0);
        chk(rd, ddpl_pkg::CTRL_RST);
        // word mode: write leaves outputs alone, load moves them
        foreach (rows[i]) begin
            apb(1'b1, ddpl_pkg::DATA_OFF, {16'h0, rows[i].data});
            cmd({30'h0, rows[i].ch, 1'b1});
            chk0();
            if (rows[i].ch) eb = rows[i].exp;
            else ea = rows[i].exp;
            cmd(32'h4);
            chk0();
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        // load issued while the write is still on the pins is refused
        apb(1'b1, ddpl_pkg::DATA_OFF, 32'h0777);
        apb(1'b1, ddpl_pkg::CMD_OFF, 32'h1);
        apb(1'b1, ddpl_pkg::CMD_OFF, 32'h4);
        chk({31'h0, er}, 32'h1);
        poll();
        chk0();
        cmd(32'h4);
        ea = 14'h0777;
        chk0();
        apb(1'b1, ddpl_pkg::CTRL_OFF, 32'h0);
        @(posedge pclk);
        chk({31'h0, hz0}, 32'h1);
        chk({31'h0, hz1}, 32'h1);
        apb(1'b1, ddpl_pkg::CTRL_OFF, 32'h10);
        apb(1'b0, ddpl_pkg::STAT_OFF, 32'h0);
        chk(rd & 32'h4, 32'h4);
        chk({31'h0, hz0}, 32'h0);
        chk({31'h0, hz1}, 32'h0);
        chk0();
        // byte-wide device on select 1: low then high byte, then load
        apb(1'b1, ddpl_pkg::CTRL_OFF, 32'h51);
        apb(1'b1, ddpl_pkg::DATA_OFF, 32'h2a34);
        cmd(32'h3);
        cmd(32'h13);
        chk({4'h0, a1, b1}, 32'h0);
        cmd(32'h4);
        chk({4'h0, a1, b1}, 32'h2a34);
        chk0();
        // sync mode: a write reaches the output with no load pulse
        apb(1'b1, ddpl_pkg::CTRL_OFF, 32'h30);
        apb(1'b1, ddpl_pkg::DATA_OFF, 32'h0123);
        cmd(32'h1);
        ea = 14'h0123;
        chk0();
        // clear together with write and load: clear wins everywhere
        cmd(32'hd);
        ea = 14'h0;
        eb = 14'h0;
        chk0();
        chk({4'h0, a1, b1}, 32'h0);
        // reset in mid-run: control back to its reset word, status cleared, pins powered
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ddpl_pkg::CTRL_OFF, 32'h0);
        chk(rd, ddpl_pkg::CTRL_RST);
        apb(1'b0, ddpl_pkg::STAT_OFF, 32'h0);
        chk(rd & 32'h3, 32'h0);
        chk({31'h0, hz0}, 32'h0);
        final_report();
    end
endmodule : ddpl_host_tb_top
